// ==== design/tlirq_core.sv ====
// Two-level interrupt controller with timers and an AXI4-Lite register slave
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module tlirq_core
  import tlirq_pkg::*;
#(
  parameter int DIV = MC_DIV
)
(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // AXI4-Lite write channels
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  // AXI4-Lite read channels
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  // Request and count pins
  input  wire logic        EXT_REQUEST_PIN_A,
  input  wire logic        EXT_REQUEST_PIN_B,
  input  wire logic        COUNT_INPUT_A,
  input  wire logic        COUNT_INPUT_B,
  // Serial frame unit events
  input  wire logic        FRAME_RX_DONE,
  input  wire logic        FRAME_RX_ERROR,
  input  wire logic        FRAME_TX_DONE,
  // Instruction sequencer
  input  wire logic        LAST_CYCLE,
  input  wire logic        RETURN_FROM_IRQ,
  output logic             CALL_REQ,
  output logic [15:0]      CALL_ADDR
);
  localparam int DW = $clog2(DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  typedef struct packed {
    logic [DW-1:0] div;
    logic [7:0]    tctl, tmode, ien, ipri;
    logic          frame, ins_hi, ins_lo;
    logic [4:0]    smp;
    logic          ipw, call;
    logic [15:0]   addr;
    logic          awr, wr, arr, awh, wh;
    logic [7:0]    awa;
    logic [31:0]   wd;
    logic [3:0]    ws;
    logic          bv;
    logic [1:0]    br;
    logic          rv;
    logic [31:0]   rd;
    logic [1:0]    rr;
  } tlirq_state_type;

  tlirq_state_type s_reg;
  tlirq_state_type s_next;

  logic            tick, we, flag_a, flag_b, ovf_a, ovfh_a, ovf_b, ok, win_hi, win_lo, run_a, run_b;
  logic [15:0]     cnt_a, cnt_b;
  logic [4:0]      pend, hi, lo, vmask;
  logic [2:0]      idx;
  logic [31:0]     rmux;
  tlirq_tmode_type mode_a, mode_b;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a inside {OFS_TCTL, OFS_TMODE, OFS_IEN, OFS_IPRI, OFS_CNTA, OFS_CNTB, OFS_STAT};
  endfunction

  function automatic logic [2:0] first_set(input logic [4:0] m);
    first_set = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (m[i])
        first_set = 3'(i);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d, input logic [1:0] b);
    merge16 = {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
  endfunction

  assign tick   = s_reg.div == DIV_LAST;
  assign we     = s_reg.awh && s_reg.wh && !s_reg.bv;
  assign mode_a = tlirq_tmode_type'(s_reg.tmode[TM_MODE +: 2]);
  assign mode_b = tlirq_tmode_type'(s_reg.tmode[TM_B_LSB + TM_MODE +: 2]);
  // Gate bit lets the request pin level hold the timer off
  assign run_a  = s_reg.tctl[TC_TR_A] && (!s_reg.tmode[TM_GATE] || EXT_REQUEST_PIN_A);
  assign run_b  = s_reg.tctl[TC_TR_B] && (!s_reg.tmode[TM_B_LSB + TM_GATE] || EXT_REQUEST_PIN_B)
                  && mode_a != TM_SPLIT;

  tlirq_ext u_ext_a (
    .clk       (CORE_CLK),
    .rst       (RST),
    .tick      (tick),
    .pin       (EXT_REQUEST_PIN_A),
    .edge_mode (s_reg.tctl[TC_IT_A]),
    .sw_we     (we && s_reg.awa == OFS_TCTL && s_reg.ws[0]),
    .sw_val    (s_reg.wd[TC_IF_A]),
    .vec_clr   (vmask[SRC_EXT_A]),
    .flag      (flag_a)
  );

  tlirq_ext u_ext_b (
    .clk       (CORE_CLK),
    .rst       (RST),
    .tick      (tick),
    .pin       (EXT_REQUEST_PIN_B),
    .edge_mode (s_reg.tctl[TC_IT_B]),
    .sw_we     (we && s_reg.awa == OFS_TCTL && s_reg.ws[0]),
    .sw_val    (s_reg.wd[TC_IF_B]),
    .vec_clr   (vmask[SRC_EXT_B]),
    .flag      (flag_b)
  );

  tlirq_timer u_tim_a (
    .clk      (CORE_CLK),
    .rst      (RST),
    .tick     (tick),
    .run      (run_a),
    .ctr_mode (s_reg.tmode[TM_CT]),
    .hi_run   (s_reg.tctl[TC_TR_B]),
    .mode     (mode_a),
    .pin      (COUNT_INPUT_A),
    .load_en  (we && s_reg.awa == OFS_CNTA),
    .load_val (merge16(cnt_a, s_reg.wd[15:0], s_reg.ws[1:0])),
    .cnt      (cnt_a),
    .ovf      (ovf_a),
    .ovf_hi   (ovfh_a)
  );

  tlirq_timer u_tim_b (
    .clk      (CORE_CLK),
    .rst      (RST),
    .tick     (tick),
    .run      (run_b),
    .ctr_mode (s_reg.tmode[TM_B_LSB + TM_CT]),
    .hi_run   (1'b0),
    .mode     (mode_b),
    .pin      (COUNT_INPUT_B),
    .load_en  (we && s_reg.awa == OFS_CNTB),
    .load_val (merge16(cnt_b, s_reg.wd[15:0], s_reg.ws[1:0])),
    .cnt      (cnt_b),
    .ovf      (ovf_b),
    .ovf_hi   ()
  );

  always_comb
  begin
    s_next      = s_reg;
    s_next.div  = tick ? '0 : s_reg.div + 1'b1;
    s_next.call = 1'b0;
    // Pending requests, each gated by its own and the global enable
    pend = {s_reg.frame, s_reg.tctl[TC_TF_B], flag_b, s_reg.tctl[TC_TF_A], flag_a}
           & s_reg.ien[NSRC-1:0] & {NSRC{s_reg.ien[IE_GLOBAL]}};
    hi     = s_reg.smp & s_reg.ipri[NSRC-1:0];
    lo     = s_reg.smp & ~s_reg.ipri[NSRC-1:0];
    ok     = tick && LAST_CYCLE && !RETURN_FROM_IRQ && !s_reg.ipw;
    win_hi = ok && (|hi) && !s_reg.ins_hi;
    win_lo = ok && (|lo) && !s_reg.ins_hi && !s_reg.ins_lo && !win_hi;
    idx    = win_hi ? first_set(hi) : first_set(lo);
    vmask  = (win_hi || win_lo) ? 5'(5'h01 << idx) : 5'h00;
    if (win_hi || win_lo)
    begin
      s_next.call   = 1'b1;
      s_next.addr   = vec_addr(idx);
      s_next.ins_hi = s_reg.ins_hi || win_hi;
      s_next.ins_lo = s_reg.ins_lo || win_lo;
    end
    if (tick && LAST_CYCLE && RETURN_FROM_IRQ)
    begin
      if (s_reg.ins_hi)
        s_next.ins_hi = 1'b0;
      else
        s_next.ins_lo = 1'b0;
    end
    // Fresh sample every machine cycle, nothing carried from a blocked poll
    if (tick)
    begin
      s_next.smp = pend & ~vmask;
      s_next.ipw = 1'b0;
    end
    // Timer flags clear on their own vector only
    if (vmask[SRC_TIM_A])
      s_next.tctl[TC_TF_A] = 1'b0;
    if (vmask[SRC_TIM_B])
      s_next.tctl[TC_TF_B] = 1'b0;
    // AXI write channels, taken in either order
    if (S_AXI_AWVALID && s_reg.awr)
    begin
      s_next.awh = 1'b1;
      s_next.awa = S_AXI_AWADDR;
      s_next.awr = 1'b0;
    end
    if (S_AXI_WVALID && s_reg.wr)
    begin
      s_next.wh = 1'b1;
      s_next.wd = S_AXI_WDATA;
      s_next.ws = S_AXI_WSTRB;
      s_next.wr = 1'b0;
    end
    if (we)
    begin
      s_next.bv  = 1'b1;
      s_next.br  = mapped(s_reg.awa) ? RESP_OKAY : RESP_SLVERR;
      s_next.awh = 1'b0;
      s_next.wh  = 1'b0;
      if (s_reg.ws[0])
      begin
        unique case (s_reg.awa)
          OFS_TCTL:  s_next.tctl = s_reg.wd[7:0];
          OFS_TMODE: s_next.tmode = s_reg.wd[7:0];
          OFS_IEN:   s_next.ien = s_reg.wd[7:0] & IEN_MASK;
          OFS_IPRI:  s_next.ipri = s_reg.wd[7:0] & IPRI_MASK;
          OFS_STAT:
            if (s_reg.wd[ST_FRAME])
              s_next.frame = 1'b0;
          default:   s_next.frame = s_reg.frame;
        endcase
      end
      if (s_reg.awa == OFS_IEN || s_reg.awa == OFS_IPRI)
        s_next.ipw = 1'b1;
    end
    if (s_reg.bv && S_AXI_BREADY)
    begin
      s_next.bv  = 1'b0;
      s_next.awr = 1'b1;
      s_next.wr  = 1'b1;
    end
    // Hardware sets win over software and vector clears
    if (ovf_a)
      s_next.tctl[TC_TF_A] = 1'b1;
    if (ovf_b || ovfh_a)
      s_next.tctl[TC_TF_B] = 1'b1;
    if (FRAME_TX_DONE || (FRAME_RX_DONE && !FRAME_RX_ERROR))
      s_next.frame = 1'b1;
    // Read channel
    rmux = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      OFS_TCTL:
      begin
        rmux[7:0]     = s_reg.tctl;
        rmux[TC_IF_A] = flag_a;
        rmux[TC_IF_B] = flag_b;
      end
      OFS_TMODE: rmux[7:0] = s_reg.tmode;
      OFS_IEN:   rmux[7:0] = s_reg.ien;
      OFS_IPRI:  rmux[7:0] = s_reg.ipri;
      OFS_CNTA:  rmux[15:0] = cnt_a;
      OFS_CNTB:  rmux[15:0] = cnt_b;
      OFS_STAT:  rmux[2:0] = {s_reg.ins_hi, s_reg.ins_lo, s_reg.frame};
      default:   rmux = 32'h0000_0000;
    endcase
    if (S_AXI_ARVALID && s_reg.arr)
    begin
      s_next.arr = 1'b0;
      s_next.rv  = 1'b1;
      s_next.rd  = rmux;
      s_next.rr  = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_reg.rv && S_AXI_RREADY)
    begin
      s_next.rv  = 1'b0;
      s_next.arr = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      s_reg       <= '0;
      s_reg.tctl  <= RST_TCTL;
      s_reg.tmode <= RST_TMODE;
      s_reg.ien   <= RST_IEN;
      s_reg.ipri  <= RST_IPRI;
      s_reg.awr   <= 1'b1;
      s_reg.wr    <= 1'b1;
      s_reg.arr   <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign S_AXI_AWREADY = s_reg.awr;
  assign S_AXI_WREADY  = s_reg.wr;
  assign S_AXI_BVALID  = s_reg.bv;
  assign S_AXI_BRESP   = s_reg.br;
  assign S_AXI_ARREADY = s_reg.arr;
  assign S_AXI_RVALID  = s_reg.rv;
  assign S_AXI_RDATA   = s_reg.rd;
  assign S_AXI_RRESP   = s_reg.rr;
  assign CALL_REQ      = s_reg.call;
  assign CALL_ADDR     = s_reg.addr;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  sequence both_held_s;
    s_reg.awh && s_reg.wh && !s_reg.bv;
  endsequence

  sequence resp_up_s;
    s_reg.bv && !s_reg.awh && !s_reg.wh;
  endsequence

  machine_tick_a: assert property (tick |-> ##12 tick)
    else $error("machine cycle tick period wrong");
  call_gate_a: assert property (s_reg.call |-> $past(tick && LAST_CYCLE && !RETURN_FROM_IRQ && !s_reg.ipw))
    else $error("call inserted while blocked");
  hi_no_preempt_a: assert property (s_reg.call |-> !$past(s_reg.ins_hi))
    else $error("high level routine was preempted");
  lo_preempt_a: assert property (s_reg.call && $past(s_reg.ins_lo) |-> s_reg.ins_hi)
    else $error("low routine preempted by low request");
  timer_clear_a: assert property (s_reg.call && s_reg.addr == vec_addr(SRC_TIM_A)
                                  |-> !s_reg.tctl[TC_TF_A] || $past(ovf_a))
    else $error("timer flag not cleared on vector");
  level_follow_a: assert property (tick && !s_reg.tctl[TC_IT_A] && !we ##1 !s_reg.tctl[TC_IT_A]
                                   |-> flag_a == !$past(EXT_REQUEST_PIN_A))
    else $error("level request flag does not follow pin");
  frame_error_a: assert property (!s_reg.frame && FRAME_RX_DONE && FRAME_RX_ERROR && !FRAME_TX_DONE
                                  |=> !s_reg.frame)
    else $error("errored frame raised a request");
  // Any earlier source at the winning level must have been idle in the polled sample
  poll_order_a: assert property (s_reg.call && s_reg.addr == vec_addr(SRC_EXT_B)
                                 |-> $past((s_reg.smp[1:0] & (s_reg.ipri[2] ? s_reg.ipri[1:0] : 2'h3)) == 2'h0))
    else $error("polling order violated");
  // Response stands until taken, and the address channel reopens only after it
  write_resp_a: assert property (both_held_s |=> resp_up_s ##1 (s_reg.bv || s_reg.awr))
    else $error("write response not raised");
endmodule // tlirq_core

// ==== design/tlirq_ext.sv ====
// External request pin sampler and request flag
`timescale 1ns/1ps
module tlirq_ext
  import tlirq_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Machine cycle and pin
  input  wire logic tick,
  input  wire logic pin,
  input  wire logic edge_mode,
  // Software and vector access
  input  wire logic sw_we,
  input  wire logic sw_val,
  input  wire logic vec_clr,
  output logic      flag
);
  typedef struct packed {
    logic pin_now;
    logic flag;
  } tlirq_ext_state_type;

  tlirq_ext_state_type s_reg;
  tlirq_ext_state_type s_next;

  always_comb
  begin
    s_next = s_reg;
    if (tick)
      s_next.pin_now = pin;
    if (vec_clr && edge_mode)
      s_next.flag = 1'b0;
    if (sw_we)
      s_next.flag = sw_val;
    // Set wins over any clear in the same cycle
    if (tick && edge_mode && s_reg.pin_now && !pin)
      s_next.flag = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_reg <= '{pin_now: 1'b1, flag: 1'b0};
    else
      s_reg <= s_next;
  end

  assign flag = edge_mode ? s_reg.flag : !s_reg.pin_now;
endmodule // tlirq_ext

// ==== design/tlirq_pkg.sv ====
// Shared constants and types for the two-level interrupt and timer block
package tlirq_pkg;
  // Machine cycle length in core clocks
  localparam int MC_DIV = 12;
  // Register byte offsets
  localparam logic [7:0] OFS_TCTL  = 8'h00;
  localparam logic [7:0] OFS_TMODE = 8'h04;
  localparam logic [7:0] OFS_IEN   = 8'h08;
  localparam logic [7:0] OFS_IPRI  = 8'h0C;
  localparam logic [7:0] OFS_CNTA  = 8'h10;
  localparam logic [7:0] OFS_CNTB  = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  // Timer control fields
  localparam int TC_IT_A = 0;
  localparam int TC_IF_A = 1;
  localparam int TC_IT_B = 2;
  localparam int TC_IF_B = 3;
  localparam int TC_TR_A = 4;
  localparam int TC_TF_A = 5;
  localparam int TC_TR_B = 6;
  localparam int TC_TF_B = 7;
  // Timer mode fields, timer B uses the upper nibble
  localparam int TM_MODE  = 0;
  localparam int TM_CT    = 2;
  localparam int TM_GATE  = 3;
  localparam int TM_B_LSB = 4;
  // Enable, priority and status fields
  localparam int IE_GLOBAL = 7;
  localparam int ST_FRAME  = 0;
  localparam int ST_INS_LO = 1;
  localparam int ST_INS_HI = 2;
  localparam int NSRC      = 5;
  // Sources in polling order
  localparam logic [2:0] SRC_EXT_A = 3'h0;
  localparam logic [2:0] SRC_TIM_A = 3'h1;
  localparam logic [2:0] SRC_EXT_B = 3'h2;
  localparam logic [2:0] SRC_TIM_B = 3'h3;
  localparam logic [2:0] SRC_FRAME = 3'h4;
  // Writable bits and reset values
  localparam logic [7:0] IEN_MASK  = 8'h9F;
  localparam logic [7:0] IPRI_MASK = 8'h1F;
  localparam logic [7:0] RST_TCTL  = 8'h00;
  localparam logic [7:0] RST_TMODE = 8'h00;
  localparam logic [7:0] RST_IEN   = 8'h00;
  localparam logic [7:0] RST_IPRI  = 8'h00;
  localparam logic [15:0] RST_CNT  = 16'h0000;
  // Service routine addresses: base plus eight bytes per source
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {TM_13BIT, TM_16BIT, TM_RELOAD8, TM_SPLIT} tlirq_tmode_type;
  function automatic logic [15:0] vec_addr(input logic [2:0] idx);
    vec_addr = VEC_BASE + {10'h000, idx, 3'h0};
  endfunction
endpackage

// ==== design/tlirq_timer.sv ====
// Timer/counter with four modes
`timescale 1ns/1ps
module tlirq_timer
  import tlirq_pkg::*;
#(
  parameter int W = 16
)
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Control
  input  wire logic            tick,
  input  wire logic            run,
  input  wire logic            ctr_mode,
  input  wire logic            hi_run,
  input  wire tlirq_tmode_type mode,
  input  wire logic            pin,
  // Software load
  input  wire logic            load_en,
  input  wire logic [W-1:0]    load_val,
  // Count and overflow pulses
  output logic [W-1:0]         cnt,
  output logic                 ovf,
  output logic                 ovf_hi
);
  localparam int H = W / 2;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pin_now;
    logic         pin_prev;
  } tlirq_tim_state_type;

  tlirq_tim_state_type s_reg;
  tlirq_tim_state_type s_next;
  logic                inc;

  always_comb
  begin
    s_next = s_reg;
    ovf    = 1'b0;
    ovf_hi = 1'b0;
    // Falling edge seen over two samples, one per machine cycle
    inc = ctr_mode ? (s_reg.pin_prev && !s_reg.pin_now) : 1'b1;
    if (tick)
    begin
      s_next.pin_now  = pin;
      s_next.pin_prev = s_reg.pin_now;
      if (run && inc)
      begin
        unique case (mode)
          TM_13BIT:
            {ovf, s_next.cnt[W-1:H], s_next.cnt[4:0]} = {1'b0, s_reg.cnt[W-1:H], s_reg.cnt[4:0]} + 14'h0001;
          TM_16BIT:
            {ovf, s_next.cnt} = {1'b0, s_reg.cnt} + {{W{1'b0}}, 1'b1};
          TM_RELOAD8:
            if (&s_reg.cnt[H-1:0])
            begin
              s_next.cnt[H-1:0] = s_reg.cnt[W-1:H];
              ovf               = 1'b1;
            end
            else
              s_next.cnt[H-1:0] = s_reg.cnt[H-1:0] + 1'b1;
          TM_SPLIT:
            {ovf, s_next.cnt[H-1:0]} = {1'b0, s_reg.cnt[H-1:0]} + {{H{1'b0}}, 1'b1};
        endcase
      end
      if (hi_run && mode == TM_SPLIT)
        {ovf_hi, s_next.cnt[W-1:H]} = {1'b0, s_reg.cnt[W-1:H]} + {{H{1'b0}}, 1'b1};
    end
    if (load_en)
      s_next.cnt = load_val;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_reg <= '{cnt: RST_CNT, pin_now: 1'b1, pin_prev: 1'b1};
    else
      s_reg <= s_next;
  end

  assign cnt = s_reg.cnt;
endmodule // tlirq_timer

// ==== verif/tlirq_core_tb.sv ====
// Self-checking bench for the interrupt controller and timers
`timescale 1ns/1ps
module tlirq_core_tb
  import tlirq_pkg::*;
;
  logic        clk, rst, awv, wv, bready, arv, rready, hold, ret_go;
  logic        awready, wready, bvalid, arready, rvalid, lastc, retirq, callreq;
  logic [1:0]  bresp, rresp;
  logic [3:0]  pn;
  logic [2:0]  fr;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [15:0] calladdr;
  int          num_errors, tests_run;

  tlirq_core #(.DIV(MC_DIV)) i_dut (
    .CORE_CLK(clk), .RST(rst),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .EXT_REQUEST_PIN_A(pn[0]), .EXT_REQUEST_PIN_B(pn[1]), .COUNT_INPUT_A(pn[2]), .COUNT_INPUT_B(pn[3]),
    .FRAME_RX_DONE(fr[0]), .FRAME_RX_ERROR(fr[1]), .FRAME_TX_DONE(fr[2]),
    .LAST_CYCLE(lastc), .RETURN_FROM_IRQ(retirq), .CALL_REQ(callreq), .CALL_ADDR(calladdr));

  tlirq_seq_model i_model (.clk(clk), .rst(rst), .hold(hold), .ret_go(ret_go), .call_req(callreq),
    .call_addr(calladdr), .last_cycle(lastc), .return_from_irq(retirq));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("wrong value %s expected %0h seen %0h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(r), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", 32'(r), 32'(rresp));
    chk("rdata", d, rdata);
  endtask

  task automatic wait_call(input logic [15:0] e);
    int n;
    n = 0;
    while (i_model.calls.size() == 0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    chk("call_seen", 32'h1, 32'(i_model.calls.size() != 0));
    if (i_model.calls.size() != 0) chk("call_addr", 32'(e), 32'(i_model.calls.pop_front()));
  endtask

  task automatic no_call(input int c);
    repeat (c) @(posedge clk);
    chk("call_count", 32'h0, 32'(i_model.calls.size()));
  endtask

  // Low for two machine cycles, then high for two, so every edge is seen
  task automatic pulse(input logic [3:0] m);
    pn <= pn & ~m;
    repeat (24) @(posedge clk);
    pn <= pn | m;
    repeat (24) @(posedge clk);
  endtask

  task automatic fev(input logic [2:0] v);
    fr <= v;
    @(posedge clk);
    fr <= 3'h0;
    @(posedge clk);
  endtask

  task automatic ret();
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    repeat (13) @(posedge clk);
  endtask

  initial
  begin
    {awv, wv, bready, arv, rready, hold, ret_go} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    pn = 4'hF;
    fr = 3'h0;
    num_errors = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h1C, 32'hFF, RESP_SLVERR);
    wr(OFS_IEN, 32'h7F, RESP_OKAY);
    rd(OFS_IEN, 32'h1F, RESP_OKAY);
    wr(OFS_TCTL, 32'h05, RESP_OKAY);
    pulse(4'h3);
    no_call(40);
    rd(OFS_TCTL, 32'h0F, RESP_OKAY);
    wr(OFS_IEN, 32'h9F, RESP_OKAY);
    wait_call(16'h0003);
    rd(OFS_TCTL, 32'h0D, RESP_OKAY);
    ret();
    wait_call(16'h0013);
    rd(OFS_TCTL, 32'h05, RESP_OKAY);
    ret();
    wr(OFS_IPRI, 32'h01, RESP_OKAY);
    pulse(4'h2);
    wait_call(16'h0013);
    pulse(4'h1);
    wait_call(16'h0003);
    pulse(4'h1);
    no_call(40);
    ret();
    wait_call(16'h0003);
    ret();
    ret();
    wr(OFS_IPRI, 32'h00, RESP_OKAY);
    wr(OFS_TCTL, 32'h00, RESP_OKAY);
    pn[1] <= 1'b0;
    wait_call(16'h0013);
    rd(OFS_TCTL, 32'h08, RESP_OKAY);
    wr(OFS_IEN, 32'h80, RESP_OKAY);
    pn[1] <= 1'b1;
    ret();
    no_call(40);
    rd(OFS_TCTL, 32'h00, RESP_OKAY);
    wr(OFS_IEN, 32'h90, RESP_OKAY);
    fev(3'h3);
    no_call(40);
    rd(OFS_STAT, 32'h00, RESP_OKAY);
    for (int i = 0; i < 2; i++)
    begin
      fev(i ? 3'h4 : 3'h1);
      wait_call(16'h0023);
      rd(OFS_STAT, 32'h03, RESP_OKAY);
      wr(OFS_STAT, 32'h01, RESP_OKAY);
      ret();
    end
    rd(OFS_STAT, 32'h00, RESP_OKAY);
    wr(OFS_IEN, 32'h82, RESP_OKAY);
    wr(OFS_CNTA, 32'hFFF0, RESP_OKAY);
    wr(OFS_TMODE, 32'h01, RESP_OKAY);
    wr(OFS_TCTL, 32'h10, RESP_OKAY);
    no_call(150);
    wait_call(16'h000B);
    rd(OFS_TCTL, 32'h10, RESP_OKAY);
    ret();
    wr(OFS_TCTL, 32'h00, RESP_OKAY);
    wr(OFS_IEN, 32'h80, RESP_OKAY);
    wr(OFS_CNTA, 32'h0, RESP_OKAY);
    wr(OFS_CNTB, 32'h0, RESP_OKAY);
    wr(OFS_TMODE, 32'h55, RESP_OKAY);
    wr(OFS_TCTL, 32'h50, RESP_OKAY);
    repeat (3) pulse(4'hC);
    rd(OFS_CNTA, 32'h3, RESP_OKAY);
    rd(OFS_CNTB, 32'h3, RESP_OKAY);
    // Reload and 13-bit counting on count pulses, then split mode with the upper half counting machine cycles
    wr(OFS_CNTA, 32'h0AFE, RESP_OKAY);
    wr(OFS_CNTB, 32'hFF1F, RESP_OKAY);
    wr(OFS_TMODE, 32'h46, RESP_OKAY);
    repeat (2) pulse(4'hC);
    rd(OFS_CNTA, 32'h0A0A, RESP_OKAY);
    rd(OFS_CNTB, 32'h0001, RESP_OKAY);
    rd(OFS_TCTL, 32'hF0, RESP_OKAY);
    wr(OFS_TCTL, 32'h00, RESP_OKAY);
    wr(OFS_CNTA, 32'hFFFE, RESP_OKAY);
    wr(OFS_TMODE, 32'h47, RESP_OKAY);
    wr(OFS_TCTL, 32'h50, RESP_OKAY);
    repeat (2) pulse(4'hC);
    rd(OFS_CNTB, 32'h0001, RESP_OKAY);
    rd(OFS_TCTL, 32'hF0, RESP_OKAY);
    wr(OFS_TCTL, 32'h01, RESP_OKAY);
    wr(OFS_IEN, 32'h81, RESP_OKAY);
    hold <= 1'b1;
    pulse(4'h1);
    no_call(40);
    hold <= 1'b0;
    wait_call(16'h0003);
    ret();
    no_call(40);
    conclude();
  end

  // The tests need under 10000 cycles; give up after 30000
  initial
  begin
    #1500000;
    num_errors++;
    conclude();
  end
endmodule // tlirq_core_tb

// ==== verif/tlirq_seq_model.sv ====
// Instruction sequencer model: logs inserted calls and drives blocking inputs
`timescale 1ns/1ps
module tlirq_seq_model
  import tlirq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bench controls
  input  wire logic        hold,
  input  wire logic        ret_go,
  // Sequencer pins
  input  wire logic        call_req,
  input  wire logic [15:0] call_addr,
  output logic             last_cycle,
  output logic             return_from_irq
);
  logic [15:0] calls[$];
  int          ret_cnt;
  // Mid-instruction cycles while the bench holds
  assign last_cycle      = !hold;
  // A return spans exactly one machine cycle, so one tick sees it
  assign return_from_irq = ret_cnt != 0;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ret_cnt <= 0;
    end
    else
    begin
      if (call_req)
      begin
        calls.push_back(call_addr);
      end
      ret_cnt <= ret_go ? MC_DIV : (ret_cnt != 0 ? ret_cnt - 1 : 0);
    end
  end
endmodule // tlirq_seq_model
